/* erl_pkg.sv */
// erl_pkg: constants and types of the error response and logging block
package erl_pkg;
	// register byte offsets
	localparam logic [7:0] ERL_CTRL    = 8'h00;
	localparam logic [7:0] ERL_STATUS  = 8'h04;
	localparam logic [7:0] ERL_INFO    = 8'h08;
	localparam logic [7:0] ERL_HARDLOG = 8'h0c;
	localparam logic [7:0] ERL_LOG_LO  = 8'h10;
	localparam logic [7:0] ERL_LOG_HI  = 8'h14;
	localparam logic [7:0] ERL_ADVMASK = 8'h18;
	localparam logic [7:0] ERL_CLEAR   = 8'h1c;
	// reset values
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] ADVMASK_RST = 32'h0000_0000;
	// control fields
	localparam int CTRL_ACT_LSB  = 0;
	localparam int CTRL_ALL_BIT  = 2;
	localparam int CTRL_TGT_LSB  = 3;
	localparam int CTRL_IRQ_LSB  = 8;
	localparam int CLR_SOFT_BIT  = 0;
	localparam int CLR_HARD_BIT  = 1;
	localparam int CLR_PSN_BIT   = 2;
	// core logic actions on a hard error
	localparam logic [1:0] ACT_INTR = 2'h0;
	localparam logic [1:0] ACT_MCHK = 2'h1;
	localparam logic [1:0] ACT_XFER = 2'h2;
	// log word, bit n here is bit 63-n in msb-first numbering
	localparam int SRC_LSB = 32;
	localparam int SRC_MSB = 35;
	// error source codes
	localparam logic [3:0] SRC_XB0_IN  = 4'h0;
	localparam logic [3:0] SRC_XB1_IN  = 4'h1;
	localparam logic [3:0] SRC_XB0_OUT = 4'h2;
	localparam logic [3:0] SRC_CSR     = 4'h5;
	// locally detected error codes
	localparam logic [4:0] ERR_ADDR_PAR = 5'h01;
	localparam logic [4:0] ERR_DATA_PAR = 5'h02;
	localparam logic [4:0] ERR_POISON   = 5'h03;
	localparam int PSN_DEPTH = 4;
	typedef enum logic [1:0] {CL_NONE, CL_ADV, CL_SOFT, CL_HARD} erl_class_t;
endpackage : erl_pkg

/* erl_reg_if.sv */
// erl_reg_if: register access strobes between bus slave and block core
`timescale 1ns/1ps
interface erl_reg_if;
	logic        wr;
	logic [7:0]  waddr;
	logic [31:0] wdata;
	logic        rd;
	logic [7:0]  raddr;
	logic [31:0] rdata;
	modport bus  (output wr, waddr, wdata, rd, raddr, input rdata);
	modport regs (input wr, waddr, wdata, rd, raddr, output rdata);
endinterface : erl_reg_if

/* erl_ahb_slave.sv */
// erl_ahb_slave: zero-wait ahb-lite slave driving register strobes
`timescale 1ns/1ps
module erl_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	erl_reg_if.bus           rb
);
	logic        wr_pend;
	logic [7:0]  wa;
	logic        next_wr_pend;
	logic [7:0]  next_wa;
	logic [31:0] next_hrdata;
	logic        acc;

	// htrans[1] covers nonseq and seq
	assign acc = hsel && hready && htrans[1];
	assign rb.rd = acc && !hwrite;
	assign rb.raddr = haddr[7:0];
	// write lands in the data phase, when hwdata is valid
	assign rb.wr = wr_pend;
	assign rb.waddr = wa;
	assign rb.wdata = hwdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		next_wr_pend = acc && hwrite;
		next_wa = acc ? haddr[7:0] : wa;
		next_hrdata = rb.rd ? rb.rdata : hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wa <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= next_wr_pend;
			wa <= next_wa;
			hrdata <= next_hrdata;
		end
	end
endmodule : erl_ahb_slave

/* erl_top.sv */
// erl_top: error classification, error responses and error logging
// How it works
// - soft errors only on response-expected transactions
// - failed response-expected request gets error response; one that fails with a hard error gets no response
// - advisory errors only logged locally, polled
// - responseless data parity is advisory, line poisoned
// - selected advisory errors raise a directed interrupt
// - unreportable or silent corruption errors are hard
// - hard errors signalled, core logic takes action
// - hard error freezes every error logging register
// - hard log keeps only the first hard error
// - hard log keeps clock phase for first-chip isolation
// - error response has no data, names detector and code
// - agent logs and forwards directed error to requester
// - four-bit error source field with fixed codes
// - info field holds crossbar error response details
// - crossbar info subfields at their fixed positions
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module erl_top
	import erl_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        det_valid,
	input  wire logic        det_resp_expected,
	input  wire logic        det_data_parity,
	input  wire logic        det_addr_parity,
	input  wire logic        det_fault,
	input  wire logic [4:0]  det_fault_code,
	input  wire logic [7:0]  det_line,
	input  wire logic [31:0] det_data,
	input  wire logic [2:0]  chip_id,
	input  wire logic [2:0]  board_id,
	input  wire logic [6:0]  node_id,
	input  wire logic [3:0]  clk_phase,
	input  wire logic        hard_in,
	output logic             resp_valid,
	output logic             resp_err,
	output logic      [31:0] resp_data,
	output logic      [4:0]  resp_code,
	output logic      [2:0]  resp_chip,
	output logic      [2:0]  resp_board,
	output logic      [6:0]  resp_node,
	output logic             hard_out,
	output logic             core_intr,
	output logic             core_mchk,
	output logic             core_xfer,
	output logic             core_all,
	output logic      [4:0]  core_target,
	output logic             adv_irq,
	output logic      [4:0]  adv_irq_target,
	input  wire logic        xr_valid,
	input  wire logic        xr_port,
	input  wire logic        xr_to_io,
	input  wire logic        xr_kind,
	input  wire logic [5:0]  xr_type,
	input  wire logic [5:0]  xr_tid,
	input  wire logic [2:0]  xr_chip,
	input  wire logic [2:0]  xr_board,
	input  wire logic [4:0]  xr_code,
	input  wire logic [6:0]  xr_node,
	input  wire logic        loc_valid,
	input  wire logic [3:0]  loc_src,
	input  wire logic [31:0] loc_info,
	input  wire logic        loc_to_io,
	output logic             dir_valid,
	output logic             dir_to_io,
	output logic      [63:0] dir_word
);
	erl_reg_if rb ();

	erl_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rb        (rb.bus)
	);

	logic [31:0] ctrl, next_ctrl;
	logic [31:0] adv_mask, next_adv_mask;
	logic        adv_sticky, next_adv_sticky;
	logic        soft_sticky, next_soft_sticky;
	logic [7:0]  adv_cnt, next_adv_cnt;
	erl_class_t  info_class, next_info_class;
	logic [4:0]  info_code, next_info_code;
	logic        info_m, next_info_m;
	logic        info_o, next_info_o;
	logic        hard_seen, next_hard_seen;
	logic        grp, next_grp;
	logic        hl_valid, next_hl_valid;
	logic        hl_simul, next_hl_simul;
	logic [3:0]  hl_phase, next_hl_phase;
	logic [12:0] hl_id, next_hl_id;
	logic [63:0] plog, next_plog;
	logic        next_resp_valid, next_resp_err;
	logic [31:0] next_resp_data;
	logic [4:0]  next_resp_code;
	logic        next_core_intr, next_core_mchk, next_core_xfer;
	logic        next_adv_irq;
	logic        next_dir_valid, next_dir_to_io;
	logic [63:0] next_dir_word;
	erl_class_t  cls;
	logic [4:0]  code;
	logic        frozen, hard_ev, first_hard, clr_soft, clr_hard, clr_psn;
	logic        psn_add, poison_hit, loc_ok;
	logic [PSN_DEPTH-1:0] psn_hit;
	logic [1:0]  psn_ptr, next_psn_ptr;
	logic [3:0]  src;
	logic [31:0] info;

	// clear register is write-only; a set with the clear wins, except info class and code when not above the logged class, and hl_valid while frozen
	assign clr_soft = rb.wr && rb.waddr == ERL_CLEAR && rb.wdata[CLR_SOFT_BIT];
	assign clr_hard = rb.wr && rb.waddr == ERL_CLEAR && rb.wdata[CLR_HARD_BIT];
	assign clr_psn  = rb.wr && rb.waddr == ERL_CLEAR && rb.wdata[CLR_PSN_BIT];
	assign frozen   = hard_seen || grp;

	// poisoned-line table, one entry per slot
	genvar gi;
	generate
		for (gi = 0; gi < PSN_DEPTH; gi++) begin : g_psn
			logic       v, next_v;
			logic [7:0] line, next_line;
			logic       wsel;
			assign wsel = psn_add && psn_ptr == 2'(gi);
			assign psn_hit[gi] = v && line == det_line;
			always_comb begin
				next_v = clr_psn ? 1'b0 : v;
				next_line = line;
				if (wsel) begin
					next_v = 1'b1;
					next_line = det_line;
				end
			end
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					v <= 1'b0;
					line <= 8'h00;
				end else begin
					v <= next_v;
					line <= next_line;
				end
			end
		end
	endgenerate
	assign poison_hit = |psn_hit;

	// classification of a detected error
	always_comb begin
		cls = CL_NONE;
		code = det_fault_code;
		if (det_valid) begin
			if (det_addr_parity) begin
				cls = CL_HARD;
			end else if (det_resp_expected) begin
				if (det_data_parity || det_fault || poison_hit) begin
					cls = CL_SOFT;
				end
			end else if (det_data_parity || det_fault) begin
				cls = CL_ADV;
			end
		end
		if (det_addr_parity) begin
			code = ERR_ADDR_PAR;
		end else if (det_data_parity) begin
			code = ERR_DATA_PAR;
		end else if (poison_hit && !det_fault) begin
			code = ERR_POISON;
		end
	end
	// one table write per poisoning; a repeat on the same line may take a second slot
	assign psn_add = cls == CL_ADV && det_data_parity && !psn_hit[psn_ptr];
	assign next_psn_ptr = psn_add ? psn_ptr + 2'd1 : psn_ptr;
	assign hard_ev = cls == CL_HARD;
	assign first_hard = hard_ev && !frozen;

	// response path: a hard error gets no response at all
	always_comb begin
		next_resp_valid = det_valid && det_resp_expected && cls != CL_HARD;
		next_resp_err = cls == CL_SOFT;
		next_resp_data = cls == CL_SOFT ? 32'h0000_0000 : det_data;
		next_resp_code = cls == CL_SOFT ? code : 5'h00;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_valid <= 1'b0;
			resp_err <= 1'b0;
			resp_data <= 32'h0000_0000;
			resp_code <= 5'h00;
			resp_chip <= 3'h0;
			resp_board <= 3'h0;
			resp_node <= 7'h00;
			psn_ptr <= 2'h0;
		end else begin
			resp_valid <= next_resp_valid;
			resp_err <= next_resp_err;
			resp_data <= next_resp_data;
			resp_code <= next_resp_code;
			resp_chip <= chip_id;
			resp_board <= board_id;
			resp_node <= node_id;
			psn_ptr <= next_psn_ptr;
		end
	end

	// local logging, frozen once any hard error is known
	always_comb begin
		next_adv_sticky = adv_sticky && !clr_soft;
		next_soft_sticky = soft_sticky && !clr_soft;
		next_adv_cnt = clr_soft ? 8'h00 : adv_cnt;
		next_info_class = info_class;
		next_info_code = info_code;
		next_info_m = info_m;
		next_info_o = info_o;
		if (clr_soft) begin
			next_info_class = CL_NONE;
			next_info_code = 5'h00;
			next_info_m = 1'b0;
			next_info_o = 1'b0;
		end
		if (cls != CL_NONE && !frozen) begin
			if (cls == CL_ADV) begin
				next_adv_sticky = 1'b1;
				if (adv_cnt != 8'hff) begin
					next_adv_cnt = adv_cnt + 8'h01;
				end
			end
			if (cls == CL_SOFT) begin
				next_soft_sticky = 1'b1;
			end
			if (cls > info_class) begin
				next_info_class = cls;
				next_info_code = code;
				next_info_o = info_class != CL_NONE;
			end else begin
				next_info_m = 1'b1;
			end
		end
		next_hard_seen = (hard_seen && !clr_hard) || hard_ev;
		next_grp = (grp && !clr_hard) || hard_in;
		next_hl_valid = hl_valid && !clr_hard;
		next_hl_simul = hl_simul;
		next_hl_phase = hl_phase;
		next_hl_id = hl_id;
		if (first_hard) begin
			next_hl_valid = 1'b1;
			next_hl_simul = hard_in;
			next_hl_phase = clk_phase;
			next_hl_id = {node_id, board_id, chip_id};
		end
		next_core_intr = first_hard && ctrl[CTRL_ACT_LSB +: 2] == ACT_INTR;
		next_core_mchk = first_hard && ctrl[CTRL_ACT_LSB +: 2] == ACT_MCHK;
		next_core_xfer = first_hard && ctrl[CTRL_ACT_LSB +: 2] == ACT_XFER;
		// only codes enabled in the mask interrupt; the rest wait for polling
		next_adv_irq = cls == CL_ADV && !frozen && adv_mask[code];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adv_sticky <= 1'b0;
			soft_sticky <= 1'b0;
			adv_cnt <= 8'h00;
			info_class <= CL_NONE;
			info_code <= 5'h00;
			info_m <= 1'b0;
			info_o <= 1'b0;
			hard_seen <= 1'b0;
			grp <= 1'b0;
			hl_valid <= 1'b0;
			hl_simul <= 1'b0;
			hl_phase <= 4'h0;
			hl_id <= 13'h0000;
			core_intr <= 1'b0;
			core_mchk <= 1'b0;
			core_xfer <= 1'b0;
			adv_irq <= 1'b0;
		end else begin
			adv_sticky <= next_adv_sticky;
			soft_sticky <= next_soft_sticky;
			adv_cnt <= next_adv_cnt;
			info_class <= next_info_class;
			info_code <= next_info_code;
			info_m <= next_info_m;
			info_o <= next_info_o;
			hard_seen <= next_hard_seen;
			grp <= next_grp;
			hl_valid <= next_hl_valid;
			hl_simul <= next_hl_simul;
			hl_phase <= next_hl_phase;
			hl_id <= next_hl_id;
			core_intr <= next_core_intr;
			core_mchk <= next_core_mchk;
			core_xfer <= next_core_xfer;
			adv_irq <= next_adv_irq;
		end
	end
	assign hard_out = hard_seen;
	assign core_all = ctrl[CTRL_ALL_BIT];
	assign core_target = ctrl[CTRL_TGT_LSB +: 5];
	assign adv_irq_target = ctrl[CTRL_IRQ_LSB +: 5];

	// processor agent: crossbar error responses take precedence over local ones
	assign loc_ok = loc_valid && loc_src >= SRC_XB0_OUT && loc_src <= SRC_CSR;
	always_comb begin
		src = xr_port ? SRC_XB1_IN : SRC_XB0_IN;
		info = {1'b0, xr_kind, xr_type, xr_tid, xr_chip, xr_board, xr_code, xr_node};
		next_dir_to_io = xr_to_io;
		if (!xr_valid) begin
			src = loc_src;
			info = loc_info;
			next_dir_to_io = loc_to_io;
		end
		next_dir_valid = xr_valid || loc_ok;
		next_dir_word = {28'h000_0000, src, info};
		next_plog = plog;
		if (next_dir_valid && !frozen) begin
			next_plog = next_dir_word;
		end
		next_ctrl = ctrl;
		next_adv_mask = adv_mask;
		if (rb.wr && rb.waddr == ERL_CTRL) begin
			next_ctrl = rb.wdata;
		end
		if (rb.wr && rb.waddr == ERL_ADVMASK) begin
			next_adv_mask = rb.wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_valid <= 1'b0;
			dir_to_io <= 1'b0;
			dir_word <= 64'h0000_0000_0000_0000;
			plog <= 64'h0000_0000_0000_0000;
			ctrl <= CTRL_RST;
			adv_mask <= ADVMASK_RST;
		end else begin
			dir_valid <= next_dir_valid;
			dir_to_io <= next_dir_to_io;
			dir_word <= next_dir_word;
			plog <= next_plog;
			ctrl <= next_ctrl;
			adv_mask <= next_adv_mask;
		end
	end

	// register read mux; unmapped offsets read zero
	always_comb begin
		unique case (rb.raddr)
			ERL_CTRL:    rb.rdata = ctrl;
			ERL_STATUS:  rb.rdata = {16'h0000, adv_cnt, 3'h0, hl_valid, grp,
				hard_seen, soft_sticky, adv_sticky};
			ERL_INFO:    rb.rdata = {23'h00_0000, info_o, info_m, info_code, info_class};
			ERL_HARDLOG: rb.rdata = {13'h0000, hl_id, hl_phase, hl_simul, hl_valid};
			ERL_LOG_LO:  rb.rdata = plog[31:0];
			ERL_LOG_HI:  rb.rdata = plog[63:32];
			ERL_ADVMASK: rb.rdata = adv_mask;
			default:     rb.rdata = 32'h0000_0000;
		endcase
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	no_resp_less_a: assert property (det_valid && !det_resp_expected |=> !resp_valid)
		else $error("responseless request answered");
	err_no_data_a: assert property (resp_valid && resp_err |-> resp_data == 32'h0 && resp_chip == chip_id)
		else $error("error response carries data");
	adv_logged_a: assert property (det_valid && !det_resp_expected && det_data_parity && !det_addr_parity && !frozen |=> adv_sticky && !resp_valid)
		else $error("advisory error not logged");
	poison_soft_a: assert property (det_valid && det_resp_expected && poison_hit && !det_addr_parity |=> resp_valid && resp_err)
		else $error("poisoned line read without soft error");
	adv_irq_cause_a: assert property (adv_irq |-> adv_sticky && $past(cls) == CL_ADV)
		else $error("advisory interrupt without advisory error");
	hard_no_resp_a: assert property (det_valid && det_addr_parity |=> hard_out && !resp_valid)
		else $error("hard error not signalled");
	freeze_log_a: assert property (frozen && !clr_hard && !clr_soft |=> $stable(plog) && $stable(info_class) && $stable(adv_cnt))
		else $error("error log changed while frozen");
	first_hard_a: assert property (hl_valid && !clr_hard |=> hl_valid && $stable(hl_phase) && $stable(hl_id))
		else $error("hard log overwritten");
	hard_action_a: assert property (first_hard |=> (core_intr || core_mchk || core_xfer ||
		ctrl[1:0] == 2'h3) ##1 !core_intr && !core_mchk && !core_xfer)
		else $error("core action not a single pulse");
	dir_log_a: assert property (dir_valid && !$past(frozen) |-> plog == dir_word)
		else $error("log and directed error differ");
	src_range_a: assert property (dir_valid |-> dir_word[SRC_MSB:SRC_LSB] <= SRC_CSR)
		else $error("reserved error source forwarded");

	soft_resp_c: cover property (resp_valid && resp_err);
	hard_first_c: cover property (first_hard ##1 hard_out);
	xr_dir_c: cover property (xr_valid ##1 dir_valid && dir_to_io);
	adv_irq_c: cover property (adv_irq);
endmodule : erl_top

/* erl_requester_model.sv */
// erl_requester_model: requesting processor and io adapter taking directed errors
`timescale 1ns/1ps
module erl_requester_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        dir_valid,
	input  wire logic        dir_to_io,
	input  wire logic [63:0] dir_word,
	output logic      [63:0] proc_log,
	output logic      [63:0] io_log,
	output logic      [7:0]  mc_count
);
	// a directed error to a processor always ends in a machine check, none is queued
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			proc_log <= 64'h0;
			io_log <= 64'h0;
			mc_count <= 8'h00;
		end else if (dir_valid) begin
			if (dir_to_io) begin
				io_log <= dir_word;
			end else begin
				proc_log <= dir_word;
				mc_count <= mc_count + 8'h01;
			end
		end
	end
endmodule : erl_requester_model

/* testbench.sv */
// testbench: directed scenarios for the error response and logging block
`timescale 1ns/1ps
module testbench
	import erl_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hard_in = 1'b0;
	logic        det_valid = 1'b0, det_resp_expected = 1'b0, det_data_parity = 1'b0;
	logic        det_addr_parity = 1'b0, det_fault = 1'b0, loc_valid = 1'b0, loc_to_io = 1'b0;
	logic        xr_valid = 1'b0, xr_port = 1'b0, xr_to_io = 1'b0, xr_kind = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2, xr_chip = 3'h0, xr_board = 3'h0, chip_id = 3'h5, board_id = 3'h2;
	logic [3:0]  clk_phase = 4'ha, loc_src = 4'h0;
	logic [4:0]  det_fault_code = 5'h00, xr_code = 5'h00;
	logic [5:0]  xr_type = 6'h00, xr_tid = 6'h00;
	logic [6:0]  node_id = 7'h11, xr_node = 7'h00;
	logic [7:0]  det_line = 8'h00, mc_count;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, det_data = 32'h0, loc_info = 32'h0, rd;
	logic [31:0] hrdata, resp_data;
	logic        hready, hreadyout, hresp, resp_valid, resp_err, hard_out, core_intr;
	logic        core_mchk, core_xfer, core_all, adv_irq, dir_valid, dir_to_io;
	logic [4:0]  resp_code, core_target, adv_irq_target;
	logic [2:0]  resp_chip, resp_board;
	logic [6:0]  resp_node;
	logic [63:0] dir_word, proc_log, io_log;
	int          err_total = 0, checked = 0;
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	erl_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
		.hrdata, .hreadyout, .hresp, .det_valid, .det_resp_expected, .det_data_parity,
		.det_addr_parity, .det_fault, .det_fault_code, .det_line, .det_data, .chip_id, .board_id,
		.node_id, .clk_phase, .hard_in, .resp_valid, .resp_err, .resp_data, .resp_code,
		.resp_chip, .resp_board, .resp_node, .hard_out, .core_intr, .core_mchk, .core_xfer,
		.core_all, .core_target, .adv_irq, .adv_irq_target, .xr_valid, .xr_port, .xr_to_io,
		.xr_kind, .xr_type, .xr_tid, .xr_chip, .xr_board, .xr_code, .xr_node, .loc_valid,
		.loc_src, .loc_info, .loc_to_io, .dir_valid, .dir_to_io, .dir_word);
	erl_requester_model i_req (.hclk, .hresetn, .dir_valid, .dir_to_io, .dir_word, .proc_log,
		.io_log, .mc_count);
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// single word transfer; read data is taken at the edge that ends the data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic det(input logic re, dp, ap, f, input logic [4:0] fc, input logic [7:0] ln);
		@(posedge hclk);
		det_valid <= 1'b1;
		det_resp_expected <= re;
		det_data_parity <= dp;
		det_addr_parity <= ap;
		det_fault <= f;
		det_fault_code <= fc;
		det_line <= ln;
		det_data <= {24'h5a5a00, ln};
		@(posedge hclk);
		det_valid <= 1'b0;
		#1;
	endtask : det
	task automatic rsp(input logic v, input logic e, input logic [4:0] c);
		chk(resp_valid, v, "resp valid");
		if (v) begin
			chk(resp_err, e, "resp err");
			chk(resp_data, e ? 32'h0 : det_data, "resp data");
			if (e) chk(resp_code, c, "resp code");
			chk({resp_node, resp_board, resp_chip}, {node_id, board_id, chip_id}, "resp id");
		end
	endtask : rsp
	// loc_info carries the inverse so a dropped local event cannot pass for the crossbar one
	task automatic agent(input logic x, l, input logic [3:0] s, input logic io, input logic [31:0] i);
		@(posedge hclk);
		xr_valid <= x;
		loc_valid <= l;
		xr_port <= s[0];
		xr_to_io <= io;
		loc_to_io <= io;
		loc_src <= s;
		loc_info <= ~i;
		{xr_kind, xr_type, xr_tid, xr_chip, xr_board, xr_code, xr_node} <= i[30:0];
		@(posedge hclk);
		xr_valid <= 1'b0;
		loc_valid <= 1'b0;
		#1;
	endtask : agent
	task automatic s_regs;
		bus(0, ERL_CTRL, 32'h0);
		chk(rd, CTRL_RST, "ctrl reset");
		bus(0, ERL_ADVMASK, 32'h0);
		chk(rd, ADVMASK_RST, "advmask reset");
		bus(1, ERL_LOG_HI, 32'hffff_ffff);
		bus(0, ERL_LOG_HI, 32'h0);
		chk(rd, 32'h0, "log read only");
		bus(1, 8'h40, 32'hffff_ffff);
		bus(0, 8'h40, 32'h0);
		chk({hresp, rd}, 33'h0, "unmapped");
	endtask : s_regs
	task automatic s_soft;
		det(1, 1, 0, 0, 5'h00, 8'h10);
		rsp(1, 1, ERR_DATA_PAR);
		det(1, 0, 0, 0, 5'h00, 8'h11);
		rsp(1, 0, 5'h00);
		det(1, 0, 0, 1, 5'h0b, 8'h12);
		rsp(1, 1, 5'h0b);
		bus(0, ERL_STATUS, 32'h0);
		chk(rd[1:0], 2'b10, "soft sticky");
		bus(1, ERL_CLEAR, 32'h1);
	endtask : s_soft
	task automatic s_adv;
		bus(1, ERL_ADVMASK, 32'h4);
		bus(1, ERL_CTRL, 32'h0000_0703);
		det(0, 1, 0, 0, 5'h00, 8'h20);
		chk({resp_valid, dir_valid}, 2'b00, "adv silent");
		chk({adv_irq, adv_irq_target}, 6'h27, "adv irq");
		bus(0, ERL_STATUS, 32'h0);
		chk(rd[1:0], 2'b01, "adv sticky");
		bus(0, ERL_INFO, 32'h0);
		chk(rd[6:0], {ERR_DATA_PAR, CL_ADV}, "adv info");
		det(1, 0, 0, 0, 5'h00, 8'h20);
		rsp(1, 1, ERR_POISON);
		bus(1, ERL_ADVMASK, 32'h0);
		det(0, 1, 0, 0, 5'h00, 8'h21);
		chk(adv_irq, 1'b0, "adv masked");
		bus(1, ERL_CLEAR, 32'h5);
	endtask : s_adv
	task automatic s_agent;
		logic [31:0] i;
		logic [7:0]  m;
		i = {1'b0, 1'b1, 6'h2a, 6'h15, 3'h6, 3'h1, 5'h13, 7'h5c};
		m = mc_count;
		for (int p = 0; p < 2; p++) begin
			agent(1, 0, p[3:0], p[0], i);
			chk({dir_valid, dir_to_io}, {1'b1, p[0]}, "dir valid");
			chk(dir_word, {31'h0, p[0], i}, "dir word");
			bus(0, ERL_LOG_LO, 32'h0);
			chk(rd, i, "log lo");
			bus(0, ERL_LOG_HI, 32'h0);
			chk(rd, {31'h0, p[0]}, "log hi");
			chk(p ? io_log : proc_log, {31'h0, p[0], i}, "far log");
		end
		chk(mc_count, m + 8'h01, "machine checks");
		for (int s = 0; s < 8; s++) begin
			agent(0, 1, s[3:0], 0, i);
			chk(dir_valid, s >= 2 && s <= 5, "local accept");
			if (s >= 2 && s <= 5) chk(dir_word, {28'h0, s[3:0], ~i}, "local word");
		end
		agent(1, 1, 4'h3, 0, i);
		chk(dir_word, {32'h1, i}, "crossbar first");
	endtask : s_agent
	task automatic s_hard(input logic [1:0] act);
		logic [31:0] hl;
		bus(1, ERL_CTRL, {24'h0, 5'h09, 1'b1, act});
		agent(1, 0, 4'h0, 0, 32'h0000_1234);
		// a group hard error in the same cycle marks the entry as simultaneous
		fork
			det(1, 0, 1, 0, 5'h00, 8'h30);
			begin
				@(posedge hclk);
				hard_in <= act[1];
			end
		join
		chk({resp_valid, hard_out}, 2'b01, "hard no resp");
		chk({core_intr, core_mchk, core_xfer}, {act == 0, act == 1, act == 2}, "act");
		chk({core_all, core_target}, 6'h29, "act target");
		@(posedge hclk);
		clk_phase <= 4'h3;
		det(0, 0, 1, 0, 5'h00, 8'h31);
		chk({core_intr, core_mchk, core_xfer}, 3'h0, "second hard");
		bus(0, ERL_HARDLOG, 32'h0);
		hl = {13'h0, node_id, board_id, chip_id, 4'ha, act[1], 1'b1};
		chk(rd, hl, "hard log");
		det(1, 1, 0, 0, 5'h00, 8'h32);
		agent(1, 0, 4'h1, 0, 32'h0000_0777);
		chk(dir_valid, 1'b1, "frozen dir");
		bus(0, ERL_LOG_HI, 32'h0);
		chk(rd, 32'h0, "log frozen");
		bus(0, ERL_STATUS, 32'h0);
		chk(rd[4:0], {1'b1, act[1], 3'b100}, "status frozen");
		hard_in <= 1'b0;
		bus(1, ERL_CLEAR, 32'h3);
		clk_phase <= 4'ha;
		bus(0, ERL_STATUS, 32'h0);
		chk(hard_out, 1'b0, "hard cleared");
	endtask : s_hard
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		s_regs();
		s_soft();
		s_adv();
		s_agent();
		for (int a = 0; a < 4; a++) s_hard(a[1:0]);
		print_verdict();
	end
	// the scenarios need a few hundred cycles; this limit leaves wide margin
	initial begin
		#40000;
		err_total++;
		print_verdict();
	end
endmodule : testbench
